// ---- pwt_pkg.sv ----
package pwt_pkg;
   typedef enum logic [1:0] {
      PWT_MODE_RAW  = 2'd0,
      PWT_MODE_PASS = 2'd1,
      PWT_MODE_TAG  = 2'd2
   } pwt_mode_t;

   localparam logic [7:0]  PWT_A_CTRL    = 8'h00;
   localparam logic [7:0]  PWT_A_STATUS  = 8'h04;
   localparam logic [7:0]  PWT_A_LABEL   = 8'h08;
   localparam logic [7:0]  PWT_A_FILL    = 8'h0c;
   localparam logic [7:0]  PWT_A_TXCNT   = 8'h10;
   localparam logic [7:0]  PWT_A_RXCNT   = 8'h14;

   localparam int          PWT_C_MODE    = 0;
   localparam int          PWT_C_CW      = 2;
   localparam int          PWT_C_SEQ     = 3;
   localparam int          PWT_C_STATS   = 4;
   localparam int          PWT_C_ROUTE   = 5;
   localparam int          PWT_C_SIG     = 6;
   localparam int          PWT_C_L3      = 7;
   localparam int          PWT_S_OPER    = 0;
   localparam int          PWT_S_REFUSE  = 1;
   localparam int          PWT_S_ACUP    = 2;
   localparam int          PWT_S_TDN     = 8;
   localparam int          PWT_S_SEQ     = 16;

   localparam logic [31:0] PWT_CTRL_RST  = 32'h0000_0004;
   localparam logic [31:0] PWT_LABEL_RST = 32'h0000_0100;
   localparam logic [15:0] PWT_FILL_RST  = 16'h0001;
   localparam logic [15:0] PWT_TPID      = 16'h8100;
   localparam logic [3:0]  PWT_CW_NIB    = 4'h0;
   localparam logic [11:0] PWT_CW_RSVD   = 12'h000;
   localparam logic [15:0] PWT_SEQ_OFF   = 16'h0000;
   localparam logic [15:0] PWT_SEQ_FIRST = 16'h0001;
   localparam logic [4:0]  PWT_TAG_POS   = 5'd12;
   localparam logic [4:0]  PWT_TAG_END   = 5'd15;
   localparam logic [1:0]  PWT_HDR_LAST  = 2'd3;
   localparam int          PWT_BOS_BIT   = 0;
   localparam logic [1:0]  PWT_BOS_BYTE  = 2'd2;
   localparam logic [1:0]  PWT_EP_UNTAG  = 2'd0;
   localparam logic [1:0]  PWT_EP_DUAL   = 2'd2;
endpackage

// ---- pwt_stat_ctr.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwt_stat_ctr
   import pwt_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         en,
   input  wire logic         clr,
   input  wire logic         inc,
   output logic      [W-1:0] count_q
);
   // Counting gated by en, the statistics enable bit of this pseudowire's control register
   always_ff @(posedge mclk) begin
      if (srst || clr) begin
         count_q <= '0;
      end else if (en && inc) begin
         count_q <= count_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- pwt_decap.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwt_decap
   import pwt_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       oper,
   input  wire logic       cw_en,
   input  wire logic [7:0] in_data,
   input  wire logic       in_valid,
   input  wire logic       in_sop,
   input  wire logic       in_eop,
   output logic            in_ready,
   output logic      [7:0] out_data_q,
   output logic            out_valid_q,
   output logic            out_sop_q,
   output logic            out_eop_q,
   input  wire logic       out_ready,
   output logic            frame_q
);
   typedef enum {DC_IDLE, DC_LBL, DC_CW, DC_BODY, DC_DROP} pwt_dc_t;
   pwt_dc_t    st_q;
   logic [1:0] idx_q;
   logic       first_q;
   logic       take;

   assign in_ready = !out_valid_q || out_ready;
   assign take     = in_valid && in_ready;

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q    <= DC_IDLE;
         idx_q   <= '0;
         first_q <= 1'b0;
      end else if (take) begin
         idx_q <= idx_q + 1'b1;
         case (st_q)
            DC_IDLE: begin
               idx_q <= 2'd1;
               if (in_sop && !in_eop) begin
                  st_q <= oper ? DC_LBL : DC_DROP;
               end
            end
            DC_LBL: begin
               // Label stack removed; last label marked by its bottom bit
               if (idx_q == PWT_BOS_BYTE && in_data[PWT_BOS_BIT]) begin
                  st_q <= DC_CW;
               end else if (idx_q == PWT_HDR_LAST && st_q == DC_CW) begin
                  st_q <= DC_CW;
               end
               if (idx_q == PWT_HDR_LAST && first_q) begin
                  st_q    <= cw_en ? DC_CW : DC_BODY;
                  first_q <= 1'b0;
                  idx_q   <= '0;
               end
               if (idx_q == PWT_BOS_BYTE && in_data[PWT_BOS_BIT]) begin
                  first_q <= 1'b1;
                  st_q    <= DC_LBL;
               end
            end
            DC_CW: begin
               // Control word discarded unread
               if (idx_q == PWT_HDR_LAST) begin
                  st_q <= DC_BODY;
               end
            end
            DC_BODY, DC_DROP: begin
               if (in_eop) begin
                  st_q <= DC_IDLE;
               end
            end
            default: st_q <= DC_IDLE;
         endcase
      end
   end

   // Payload and its VLAN tags delivered untouched
   always_ff @(posedge mclk) begin
      if (srst) begin
         out_valid_q <= 1'b0;
         out_data_q  <= '0;
         out_sop_q   <= 1'b0;
         out_eop_q   <= 1'b0;
         frame_q     <= 1'b0;
      end else begin
         frame_q <= 1'b0;
         if (in_ready) begin
            out_valid_q <= take && st_q == DC_BODY;
            out_data_q  <= in_data;
            out_eop_q   <= in_eop;
            out_sop_q   <= st_q == DC_BODY && !out_valid_q && idx_q == 2'd0;
            frame_q     <= take && st_q == DC_BODY && in_eop;
         end
      end
   end
endmodule
`default_nettype wire

// ---- pwt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwt_top
   import pwt_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ac_up,
   input  wire logic        stats_res_grant,
   input  wire logic [7:0]  ac_rx_data,
   input  wire logic        ac_rx_valid,
   input  wire logic        ac_rx_sop,
   input  wire logic        ac_rx_eop,
   input  wire logic [1:0]  ac_rx_tags,
   output logic             ac_rx_ready_q,
   output logic      [7:0]  pw_tx_data_q,
   output logic             pw_tx_valid_q,
   output logic             pw_tx_sop_q,
   output logic             pw_tx_eop_q,
   input  wire logic        pw_tx_ready,
   input  wire logic [7:0]  pw_rx_data,
   input  wire logic        pw_rx_valid,
   input  wire logic        pw_rx_sop,
   input  wire logic        pw_rx_eop,
   output logic             pw_rx_ready_q,
   output logic      [7:0]  ac_tx_data_q,
   output logic             ac_tx_valid_q,
   output logic             ac_tx_sop_q,
   output logic             ac_tx_eop_q,
   input  wire logic        ac_tx_ready,
   output logic             pw_oper_q,
   output logic             pw_teardown_q
);
   typedef enum {EN_IDLE, EN_LBL, EN_CW, EN_BODY, EN_INS, EN_DROP} pwt_en_t;

   logic [31:0] ctrl_q, label_q, rd_d, tx_cnt, rx_cnt;
   logic [15:0] fill_q, seq_q;
   logic [7:0]  tdn_q;
   logic        refuse_q, fire, wr, ac_up_q, res_q, rx_frame, tx_frame_q;
   logic        dc_ready;
   pwt_mode_t   mode, new_mode;
   logic [31:0] ctrl_w, fill_w;

   function automatic logic [31:0] pwt_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign mode     = pwt_mode_t'(ctrl_q[PWT_C_MODE +: 2]);
   assign fire     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr       = fire && wb_we_i;
   assign ctrl_w   = pwt_merge(ctrl_q, wb_dat_i, wb_sel_i);
   assign new_mode = pwt_mode_t'(ctrl_w[PWT_C_MODE +: 2]);
   assign fill_w   = pwt_merge({16'h0000, fill_q}, wb_dat_i, wb_sel_i);

   // Bus answer one cycle after the request; unmapped reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= fire;
         wb_dat_o <= rd_d;
      end
   end

   always_comb begin
      case (wb_adr_i)
         PWT_A_CTRL:   rd_d = ctrl_q;
         PWT_A_STATUS: rd_d = {seq_q, tdn_q, 5'd0, ac_up_q, refuse_q, pw_oper_q};
         PWT_A_LABEL:  rd_d = label_q;
         PWT_A_FILL:   rd_d = {16'h0000, fill_q};
         PWT_A_TXCNT:  rd_d = tx_cnt;
         PWT_A_RXCNT:  rd_d = rx_cnt;
         default:      rd_d = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         label_q <= PWT_LABEL_RST;
         fill_q  <= PWT_FILL_RST;
      end else if (wr && wb_adr_i == PWT_A_LABEL) begin
         label_q <= pwt_merge(label_q, wb_dat_i, wb_sel_i);
      end else if (wr && wb_adr_i == PWT_A_FILL) begin
         fill_q <= fill_w[15:0];
      end
   end

   // Control register with mode-change policing
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_q        <= PWT_CTRL_RST;
         refuse_q      <= 1'b0;
         tdn_q         <= '0;
         pw_teardown_q <= 1'b0;
      end else begin
         pw_teardown_q <= 1'b0;
         if (wr && wb_adr_i == PWT_A_STATUS && wb_sel_i[0] && wb_dat_i[PWT_S_REFUSE]) begin
            refuse_q <= 1'b0;
         end
         if (wr && wb_adr_i == PWT_A_CTRL) begin
            if (new_mode == PWT_MODE_RAW && mode != PWT_MODE_RAW && ctrl_w[PWT_C_ROUTE]) begin
               refuse_q <= 1'b1;
               ctrl_q   <= {ctrl_w[31:2], ctrl_q[1:0]};
            end else begin
               ctrl_q <= ctrl_w;
               if (new_mode != mode && !((new_mode == PWT_MODE_RAW && mode == PWT_MODE_PASS) ||
                                         (new_mode == PWT_MODE_PASS && mode == PWT_MODE_RAW))) begin
                  ctrl_q[PWT_C_SIG] <= 1'b0;
                  pw_teardown_q     <= 1'b1;
                  tdn_q             <= tdn_q + 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ac_up_q   <= 1'b0;
         res_q     <= 1'b0;
         pw_oper_q <= 1'b0;
      end else begin
         ac_up_q   <= ac_up;
         res_q     <= stats_res_grant;
         pw_oper_q <= ctrl_q[PWT_C_SIG] && ctrl_q[PWT_C_L3] && ac_up_q
                      && (!ctrl_q[PWT_C_STATS] || res_q);
      end
   end

   // Ingress encapsulator
   pwt_en_t     st_q;
   pwt_mode_t   fmode_q;
   logic [1:0]  tags_q, idx_q;
   logic [4:0]  pos_q;
   logic        ins_done_q, adv, take, strip, need_ins;
   logic [31:0] cw, hdr;

   assign adv      = !pw_tx_valid_q || pw_tx_ready;
   assign cw       = {PWT_CW_NIB, PWT_CW_RSVD, seq_q};
   assign hdr      = st_q == EN_CW ? cw : (st_q == EN_INS ? {PWT_TPID, fill_q} : label_q);
   assign strip    = pos_q >= PWT_TAG_POS && pos_q <= PWT_TAG_END &&
                     ((fmode_q == PWT_MODE_RAW && tags_q != PWT_EP_UNTAG) ||
                      (fmode_q == PWT_MODE_TAG && tags_q == PWT_EP_DUAL));
   assign need_ins = fmode_q == PWT_MODE_TAG && tags_q == PWT_EP_UNTAG &&
                     pos_q == PWT_TAG_POS && !ins_done_q;
   assign take     = adv && ac_rx_valid && !ac_rx_ready_q && ((st_q == EN_BODY && !need_ins) || st_q == EN_DROP ||
                     (st_q == EN_IDLE && !ac_rx_sop));

   always_ff @(posedge mclk) begin
      if (srst) begin
         ac_rx_ready_q <= 1'b0;
      end else begin
         ac_rx_ready_q <= take;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q       <= EN_IDLE;
         fmode_q    <= PWT_MODE_RAW;
         tags_q     <= '0;
         idx_q      <= '0;
         pos_q      <= '0;
         ins_done_q <= 1'b0;
      end else if (adv) begin
         case (st_q)
            EN_IDLE: begin
               if (ac_rx_valid && ac_rx_sop) begin
                  fmode_q    <= mode;
                  tags_q     <= ac_rx_tags;
                  idx_q      <= '0;
                  pos_q      <= '0;
                  ins_done_q <= 1'b0;
                  st_q       <= pw_oper_q ? EN_LBL : EN_DROP;
               end
            end
            EN_LBL: begin
               idx_q <= idx_q + 1'b1;
               if (idx_q == PWT_HDR_LAST) begin
                  st_q <= ctrl_q[PWT_C_CW] ? EN_CW : EN_BODY;
               end
            end
            EN_CW, EN_INS: begin
               idx_q <= idx_q + 1'b1;
               if (idx_q == PWT_HDR_LAST) begin
                  st_q <= EN_BODY;
               end
            end
            EN_BODY: begin
               if (need_ins) begin
                  st_q       <= EN_INS;
                  ins_done_q <= 1'b1;
               end else if (take) begin
                  if (pos_q != 5'h1f) begin
                     pos_q <= pos_q + 1'b1;
                  end
                  if (ac_rx_eop) begin
                     st_q <= EN_IDLE;
                  end
               end
            end
            EN_DROP: begin
               if (take && ac_rx_eop) begin
                  st_q <= EN_IDLE;
               end
            end
            default: st_q <= EN_IDLE;
         endcase
      end
   end

   // Sequence number advances per frame and skips zero while sequencing (the SEQ control bit) is on
   always_ff @(posedge mclk) begin
      if (srst) begin
         seq_q <= PWT_SEQ_OFF;
      end else if (!ctrl_q[PWT_C_SEQ]) begin
         seq_q <= PWT_SEQ_OFF;
      end else if (seq_q == PWT_SEQ_OFF) begin
         seq_q <= PWT_SEQ_FIRST;
      end else if (tx_frame_q) begin
         seq_q <= (seq_q == 16'hffff) ? PWT_SEQ_FIRST : seq_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pw_tx_valid_q <= 1'b0;
         pw_tx_data_q  <= '0;
         pw_tx_sop_q   <= 1'b0;
         pw_tx_eop_q   <= 1'b0;
         tx_frame_q    <= 1'b0;
      end else begin
         tx_frame_q <= 1'b0;
         if (adv) begin
            pw_tx_sop_q <= 1'b0;
            pw_tx_eop_q <= 1'b0;
            case (st_q)
               EN_LBL, EN_CW, EN_INS: begin
                  pw_tx_valid_q <= 1'b1;
                  pw_tx_data_q  <= hdr[8*(3-idx_q) +: 8];
                  pw_tx_sop_q   <= st_q == EN_LBL && idx_q == 2'd0;
               end
               EN_BODY: begin
                  // Bytes pass as received unless a tag is being removed
                  pw_tx_valid_q <= take && !strip;
                  pw_tx_data_q  <= ac_rx_data;
                  pw_tx_eop_q   <= take && ac_rx_eop;
                  tx_frame_q    <= take && ac_rx_eop;
               end
               default: pw_tx_valid_q <= 1'b0;
            endcase
         end
      end
   end

   pwt_decap u_decap (
      .mclk        (mclk),
      .srst        (srst),
      .oper        (pw_oper_q),
      .cw_en       (ctrl_q[PWT_C_CW]),
      .in_data     (pw_rx_data),
      .in_valid    (pw_rx_valid),
      .in_sop      (pw_rx_sop),
      .in_eop      (pw_rx_eop),
      .in_ready    (dc_ready),
      .out_data_q  (ac_tx_data_q),
      .out_valid_q (ac_tx_valid_q),
      .out_sop_q   (ac_tx_sop_q),
      .out_eop_q   (ac_tx_eop_q),
      .out_ready   (ac_tx_ready),
      .frame_q     (rx_frame)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         pw_rx_ready_q <= 1'b0;
      end else begin
         pw_rx_ready_q <= dc_ready;
      end
   end

   pwt_stat_ctr #(.W(32)) u_txcnt (
      .mclk    (mclk),
      .srst    (srst),
      .en      (ctrl_q[PWT_C_STATS]),
      .clr     (wr && wb_adr_i == PWT_A_TXCNT),
      .inc     (tx_frame_q),
      .count_q (tx_cnt)
   );

   pwt_stat_ctr #(.W(32)) u_rxcnt (
      .mclk    (mclk),
      .srst    (srst),
      .en      (ctrl_q[PWT_C_STATS]),
      .clr     (wr && wb_adr_i == PWT_A_RXCNT),
      .inc     (rx_frame),
      .count_q (rx_cnt)
   );
endmodule
`default_nettype wire

// ---- pwt_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwt_top_props (
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       ac_up,
   input wire logic       ac_rx_ready_q,
   input wire logic       pw_oper_q,
   input wire logic       pw_teardown_q,
   input wire logic [7:0] pw_tx_data_q,
   input wire logic       pw_tx_valid_q,
   input wire logic       pw_tx_sop_q,
   input wire logic       pw_tx_ready,
   input wire logic [7:0] ac_tx_data_q,
   input wire logic       ac_tx_valid_q,
   input wire logic       ac_tx_ready
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack unasked");
   tdn_pulse_a: assert property (pw_teardown_q |=> !pw_teardown_q)
      else $error("teardown too long");
   tdn_drop_a: assert property (pw_teardown_q |-> ##[0:3] !pw_oper_q)
      else $error("oper kept after teardown");
   oper_ac_a: assert property ((!ac_up) [*4] |-> !pw_oper_q)
      else $error("oper without endpoint");
   tx_hold_a: assert property (pw_tx_valid_q && !pw_tx_ready |=> pw_tx_valid_q && $stable(pw_tx_data_q))
      else $error("pw byte lost");
   ac_hold_a: assert property (ac_tx_valid_q && !ac_tx_ready |=> ac_tx_valid_q && $stable(ac_tx_data_q))
      else $error("ac byte lost");
   tx_sop_a: assert property (pw_tx_sop_q |-> pw_tx_valid_q)
      else $error("sop without valid");
   rx_ack_a: assert property (ac_rx_ready_q |=> !ac_rx_ready_q)
      else $error("ingress take twice");
endmodule
bind pwt_top pwt_top_props u_props (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .ac_up(ac_up), .ac_rx_ready_q(ac_rx_ready_q), .pw_oper_q(pw_oper_q),
   .pw_teardown_q(pw_teardown_q), .pw_tx_data_q(pw_tx_data_q), .pw_tx_valid_q(pw_tx_valid_q),
   .pw_tx_sop_q(pw_tx_sop_q), .pw_tx_ready(pw_tx_ready), .ac_tx_data_q(ac_tx_data_q),
   .ac_tx_valid_q(ac_tx_valid_q), .ac_tx_ready(ac_tx_ready));
`default_nettype wire

// ---- pwt_net_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwt_net_model (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       slow,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic      [7:0] rx_data,
   output logic            rx_valid,
   output logic            rx_sop,
   output logic            rx_eop,
   input  wire logic       rx_ready
);
   logic [7:0] got_q[$];
   logic [9:0] out_q[$];
   logic       ph_q;
   // Slow mode stalls every other cycle so the block must hold its byte
   always @(posedge mclk) begin
      ph_q <= !ph_q && !srst;
      tx_ready <= !srst && (!slow || ph_q);
      if (!srst && tx_valid && tx_ready) got_q.push_back(tx_data);
   end
   always @(posedge mclk) begin
      if (srst) begin
         {rx_valid, rx_sop, rx_eop, rx_data} <= 11'h000;
      end else if (!rx_valid || rx_ready) begin
         if (out_q.size() > 0) begin
            {rx_sop, rx_eop, rx_data} <= out_q.pop_front();
            rx_valid <= 1'b1;
         end else begin
            {rx_valid, rx_sop, rx_eop} <= 3'h0;
            // Idle data toggles so a stale byte never looks valid
            rx_data <= ~rx_data;
         end
      end
   end
   task automatic load(input logic [7:0] b[$]);
      foreach (b[i]) out_q.push_back({i == 0, i == b.size() - 1, b[i]});
   endtask
   // Transit view: payload kind from the nibble after the bottom label
   function automatic logic [3:0] kind();
      int k;
      k = 0;
      while (k + 4 < got_q.size() && !got_q[k + 2][0]) k += 4;
      return (k + 4 < got_q.size()) ? got_q[k + 4][7:4] : 4'hf;
   endfunction
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pwt_pkg::*;
;
   logic        mclk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00, ac_rx_data = 8'h00, pw_tx_data_q, pw_rx_data, ac_tx_data_q;
   logic [9:0]  acq[$];
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [1:0]  ac_rx_tags = 2'h0;
   logic        wb_ack_o, ac_up = 1'b0, stats_res_grant = 1'b0, ac_tx_ready = 1'b1, slow = 1'b0;
   logic        ac_rx_valid = 1'b0, ac_rx_sop = 1'b0, ac_rx_eop = 1'b0, ac_rx_ready_q, pw_tx_valid_q;
   logic        pw_tx_sop_q, pw_tx_eop_q, pw_tx_ready, pw_rx_valid, pw_rx_sop, pw_rx_eop, pw_rx_ready_q;
   logic        ac_tx_valid_q, ac_tx_sop_q, ac_tx_eop_q, pw_oper_q, pw_teardown_q;
   int          mismatches = 0, checks = 0;
   always #2.5 mclk = ~mclk;
   pwt_top dut (.*);
   pwt_net_model net (.mclk(mclk), .srst(srst), .slow(slow), .tx_data(pw_tx_data_q), .tx_valid(pw_tx_valid_q),
      .tx_ready(pw_tx_ready), .rx_data(pw_rx_data), .rx_valid(pw_rx_valid), .rx_sop(pw_rx_sop),
      .rx_eop(pw_rx_eop), .rx_ready(!ac_tx_valid_q || ac_tx_ready));
   always @(posedge mclk) if (ac_tx_valid_q && ac_tx_ready) acq.push_back({ac_tx_sop_q, ac_tx_eop_q, ac_tx_data_q});
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tmo(input bit bad);
      if (bad) begin
         chk("timeout", 32'h0000_0000, 32'h0000_0001);
         report_and_stop();
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      tmo(n >= 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, rd);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(1'b0, a, 32'h0000_0000, rd);
      chk(n, rd, e);
   endtask
   task automatic settle(input logic e);
      repeat (6) @(posedge mclk);
      chk("oper", {31'h0, pw_oper_q}, {31'h0, e});
   endtask
   // One 20-byte frame in; expected image built from mode, tags and control word
   task automatic ing(input logic [1:0] md, tg, input logic [15:0] sq, input logic cw);
      logic [7:0] e[$];
      int         i, n;
      e = {8'h12, 8'h34, 8'h51, 8'h01};
      if (cw) e = {e, 8'h00, 8'h00, sq[15:8], sq[7:0]};
      for (int k = 0; k < 20; k++) begin
         if (k == 12 && md == PWT_MODE_TAG && tg == 2'h0) e = {e, 8'h81, 8'h00, 8'h00, 8'h01};
         if (k < 12 || k > 15 || !(md == PWT_MODE_RAW && tg != 2'h0 || md == PWT_MODE_TAG && tg == 2'h2))
            e.push_back(8'h40 + k[7:0]);
      end
      net.got_q.delete();
      ac_rx_tags <= tg;
      i = 0;
      n = 0;
      while (i < 20 && n < 400) begin
         {ac_rx_valid, ac_rx_sop, ac_rx_eop, ac_rx_data} <= {1'b1, i == 0, i == 19, 8'h40 + i[7:0]};
         @(posedge mclk);
         n++;
         if (ac_rx_ready_q === 1'b1) i++;
      end
      ac_rx_valid <= 1'b0;
      @(posedge mclk);
      tmo(i < 20);
      while (net.got_q.size() < e.size() && n < 800) begin
         @(posedge mclk);
         n++;
      end
      tmo(n >= 800);
      chk("pw len", net.got_q.size(), e.size());
      foreach (e[k]) chk("pw byte", {24'h0, net.got_q[k]}, {24'h0, e[k]});
      chk("pw kind", {28'h0, net.kind()}, cw ? 32'h0000_0000 : 32'h0000_0004);
   endtask
   task automatic eg();
      logic [7:0] f[$];
      int         n;
      // Two labels, bottom one flagged, then a control word with reserved bits set
      f = {8'h11, 8'h22, 8'h30, 8'hff, 8'h12, 8'h34, 8'h51, 8'h40, 8'h0f, 8'hff, 8'h00, 8'h00};
      for (int k = 0; k < 20; k++) f.push_back(8'h80 + k[7:0]);
      acq.delete();
      ac_tx_ready <= 1'b0;
      net.load(f);
      repeat (12) @(posedge mclk);
      ac_tx_ready <= 1'b1;
      n = 0;
      while (acq.size() < 20 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      tmo(n >= 400);
      repeat (5) @(posedge mclk);
      chk("ac len", acq.size(), 32'h0000_0014);
      foreach (acq[k]) chk("ac byte", {22'h0, acq[k]}, {22'h0, k == 0, k == 19, 8'h80 + k[7:0]});
   endtask
   task automatic t_regs();
      rc(PWT_A_CTRL, 32'h0000_0004, "ctrl rst");
      rc(PWT_A_LABEL, 32'h0000_0100, "label rst");
      rc(PWT_A_FILL, 32'h0000_0001, "fill rst");
      wb_sel_i <= 4'h1;
      wr(PWT_A_FILL, 32'hffff_ff5c);
      rc(PWT_A_FILL, 32'h0000_005c, "fill lane");
      wr(PWT_A_FILL, 32'h0000_0001);
      wb_sel_i <= 4'hf;
      rc(PWT_A_STATUS, 32'h0000_0000, "status rst");
      wr(8'h20, 32'hffff_ffff);
      rc(8'h20, 32'h0000_0000, "unmapped");
      wr(PWT_A_LABEL, 32'h1234_5101);
      rc(PWT_A_LABEL, 32'h1234_5101, "label");
   endtask
   task automatic t_oper();
      wr(PWT_A_CTRL, 32'h0000_00c4);
      settle(1'b0);
      ac_up <= 1'b1;
      settle(1'b1);
      wr(PWT_A_CTRL, 32'h0000_00d4);
      settle(1'b0);
      stats_res_grant <= 1'b1;
      settle(1'b1);
   endtask
   task automatic t_modes();
      for (int t = 0; t < 3; t++) ing(PWT_MODE_RAW, t[1:0], 16'h0000, 1'b1);
      wr(PWT_A_CTRL, 32'h0000_00d5);
      settle(1'b1);
      wb(1'b0, PWT_A_STATUS, 32'h0000_0000, rd);
      chk("tdn count", {24'h0, rd[15:8]}, 32'h0000_0000);
      for (int t = 0; t < 3; t++) ing(PWT_MODE_PASS, t[1:0], 16'h0000, 1'b1);
      eg();
      wr(PWT_A_CTRL, 32'h0000_00dd);
      ing(PWT_MODE_PASS, 2'h1, 16'h0001, 1'b1);
      ing(PWT_MODE_PASS, 2'h1, 16'h0002, 1'b1);
      wr(PWT_A_CTRL, 32'h0000_00d1);
      ing(PWT_MODE_PASS, 2'h0, 16'h0000, 1'b0);
      wr(PWT_A_CTRL, 32'h0000_00d6);
      settle(1'b0);
      rc(PWT_A_CTRL, 32'h0000_0096, "sig cleared");
      wr(PWT_A_CTRL, 32'h0000_00d6);
      settle(1'b1);
      slow <= 1'b1;
      for (int t = 0; t < 3; t++) ing(PWT_MODE_TAG, t[1:0], 16'h0000, 1'b1);
   endtask
   task automatic t_refuse();
      wr(PWT_A_CTRL, 32'h0000_00f4);
      rc(PWT_A_CTRL, 32'h0000_00f6, "mode kept");
      wb(1'b0, PWT_A_STATUS, 32'h0000_0000, rd);
      chk("status", {16'h0, rd[15:0]}, 32'h0000_0107);
      wr(PWT_A_STATUS, 32'h0000_0002);
      wb(1'b0, PWT_A_STATUS, 32'h0000_0000, rd);
      chk("refuse clr", {30'h0, rd[1:0]}, 32'h0000_0001);
      rc(PWT_A_TXCNT, 32'h0000_000c, "tx frames");
      rc(PWT_A_RXCNT, 32'h0000_0001, "rx frames");
      wr(PWT_A_TXCNT, 32'h0000_0000);
      rc(PWT_A_TXCNT, 32'h0000_0000, "tx clear");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_oper();
      t_modes();
      t_refuse();
      report_and_stop();
   end
endmodule
`default_nettype wire
